// >>> logic/rwic_top.v
// reset sequencing, watchdog register and interrupt vector selection
`include "rwic_defs.vh"
module rwic_top
(
  input wire clk_in,
  input wire rst_in,
  input wire ext_reset_n_in,
  input wire [7:0] addr_in,
  input wire [7:0] wdata_in,
  input wire wr_in,
  input wire rd_in,
  input wire last_cycle_in,
  input wire return_from_interrupt_instr_in,
  input wire stop_in,
  input wire nmi_req_in,
  input wire timer3_req_in,
  input wire porta_req_in,
  input wire portb_req_in,
  input wire timer2_req_in,
  input wire vsync_req_in,
  input wire twowire_req_in,
  input wire timer1_req_in,
  input wire ddc_req_in,
  input wire adc_req_in,
  input wire power_event_input,
  output reg [7:0] rdata_out,
  output reg core_reset_out,
  output reg ports_pullup_out,
  output reg stack_clear_out,
  output reg pc_load_out,
  output reg [11:0] pc_vector_out,
  output reg [1:0] flag_mode_out,
  output reg wait_out,
  output reg machine_cycle_out
);
  reg ext_s1_reg;
  reg ext_s2_reg;
  reg [4:0] req_s1_reg;
  reg [4:0] req_s2_reg;
  reg [4:0] req_d_reg;
  reg [4:0] pend_reg;
  reg [4:0] pend_next;
  reg [11:0] stab_reg;
  reg [3:0] wd_div_reg;
  reg [3:0] mc_div_reg;
  reg wd_tick_reg;
  reg global_irq_enable;
  reg soft_reset_reg;
  reg [1:0] nest_reg;
  reg in_reset_reg;
  wire wd_expire;
  wire [7:0] wdog_value;
  wire wdog_wr;
  wire ior_wr;
  wire reset_cause;
  wire [4:0] req_raw;
  wire [4:0] req_fall;
  wire [2:0] pick;
  wire take;

  // source groups are wired-and low-active: any low request pulls the line
  assign req_raw[0] = nmi_req_in;
  assign req_raw[1] = timer3_req_in & porta_req_in & portb_req_in;
  assign req_raw[2] = timer2_req_in & vsync_req_in & twowire_req_in;
  assign req_raw[3] = timer1_req_in & ddc_req_in;
  assign req_raw[4] = adc_req_in & power_event_input;
  assign req_fall = req_d_reg & ~req_s2_reg;

  // register decode for the two data-space locations
  assign wdog_wr = wr_in && (addr_in == `RWIC_WDOG_ADDR);
  assign ior_wr = wr_in && (addr_in == `RWIC_IOR_ADDR);
  assign reset_cause = ~ext_s2_reg | wd_expire | soft_reset_reg;

  // highest-priority pending vector, nmi first then 1..4
  function [2:0] prio;
    input [4:0] p;
    input allow_mask;
    begin
      if (p[0])
        prio = 3'h0;
      else if (allow_mask && p[1])
        prio = 3'h1;
      else if (allow_mask && p[2])
        prio = 3'h2;
      else if (allow_mask && p[3])
        prio = 3'h3;
      else if (allow_mask && p[4])
        prio = 3'h4;
      else
        prio = 3'h7;
    end
  endfunction

  // vector address for a selected number
  function [11:0] vec_addr;
    input [2:0] n;
    begin
      if (n == 3'h0)
        vec_addr = `RWIC_VEC_NMI;
      else if (n == 3'h1)
        vec_addr = `RWIC_VEC_1;
      else if (n == 3'h2)
        vec_addr = `RWIC_VEC_2;
      else if (n == 3'h3)
        vec_addr = `RWIC_VEC_3;
      else
        vec_addr = `RWIC_VEC_4;
    end
  endfunction

  // maskable allowed only in normal mode with global enable
  assign pick = prio(pend_reg, global_irq_enable && nest_reg == `RWIC_MODE_NORMAL);
  assign take = last_cycle_in && !in_reset_reg && pick != 3'h7
    && !(pick == 3'h0 && nest_reg == `RWIC_MODE_NMI);

  // pin and request synchronisers
  always @(posedge clk_in)
  begin
    if (rst_in)
    begin
      ext_s1_reg <= 1'b1;
      ext_s2_reg <= 1'b1;
      req_s1_reg <= 5'h1F;
      req_s2_reg <= 5'h1F;
      req_d_reg <= 5'h1F;
    end
    else
    begin
      ext_s1_reg <= ext_reset_n_in;
      ext_s2_reg <= ext_s1_reg;
      req_s1_reg <= req_raw;
      req_s2_reg <= req_s1_reg;
      req_d_reg <= req_s2_reg;
    end
  end

  // clock dividers: watchdog tick osc/12, machine cycle osc/13
  always @(posedge clk_in)
  begin
    if (rst_in)
    begin
      wd_div_reg <= 4'h0;
      mc_div_reg <= 4'h0;
      wd_tick_reg <= 1'b0;
      machine_cycle_out <= 1'b0;
    end
    else
    begin
      wd_tick_reg <= (wd_div_reg == `RWIC_WD_DIV - 4'h1);
      wd_div_reg <= (wd_div_reg == `RWIC_WD_DIV - 4'h1) ? 4'h0 : wd_div_reg + 4'h1;
      machine_cycle_out <= (mc_div_reg == `RWIC_MC_DIV - 4'h1);
      mc_div_reg <= (mc_div_reg == `RWIC_MC_DIV - 4'h1) ? 4'h0 : mc_div_reg + 4'h1;
    end
  end

  // reset sequencer: any cause reloads the stabilisation count
  always @(posedge clk_in)
  begin
    if (rst_in)
    begin
      stab_reg <= `RWIC_STAB_CYCLES;
      in_reset_reg <= 1'b1;
      soft_reset_reg <= 1'b0;
    end
    else
    begin
      soft_reset_reg <= wdog_wr && !in_reset_reg && !wdata_in[`RWIC_SR_BIT];
      if (reset_cause)
      begin
        stab_reg <= `RWIC_STAB_CYCLES;
        in_reset_reg <= 1'b1;
      end
      else if (stab_reg != 12'h000)
        stab_reg <= stab_reg - 12'h001;
      else
        in_reset_reg <= 1'b0;
    end
  end

  // pending flags: stored edge; detect clears; repeats ignored while set
  always @*
  begin
    pend_next = pend_reg | req_fall;
    if (take)
      pend_next[pick] = req_fall[pick];
  end

  // interrupt state, flag mode and core-facing outputs
  always @(posedge clk_in)
  begin
    if (rst_in || in_reset_reg)
    begin
      pend_reg <= 5'h00;
      nest_reg <= `RWIC_MODE_NMI;
      global_irq_enable <= 1'b0;
      core_reset_out <= 1'b1;
      ports_pullup_out <= 1'b1;
      stack_clear_out <= 1'b1;
      pc_load_out <= 1'b1;
      pc_vector_out <= `RWIC_VEC_RESET;
      flag_mode_out <= `RWIC_MODE_NMI;
      wait_out <= 1'b0;
    end
    else
    begin
      core_reset_out <= 1'b0;
      ports_pullup_out <= 1'b0;
      stack_clear_out <= 1'b0;
      pend_reg <= pend_next;
      if (ior_wr)
        global_irq_enable <= wdata_in[`RWIC_GEN_BIT];
      wait_out <= stop_in;
      pc_load_out <= take;
      pc_vector_out <= vec_addr(pick);
      if (take)
      begin
        nest_reg <= (pick == 3'h0) ? `RWIC_MODE_NMI : `RWIC_MODE_IRQ;
        flag_mode_out <= (pick == 3'h0) ? `RWIC_MODE_NMI : `RWIC_MODE_IRQ;
      end
      else if (return_from_interrupt_instr_in)
      begin
        // return drops to normal; pending maskable ones wait for the next last cycle
        nest_reg <= `RWIC_MODE_NORMAL;
        flag_mode_out <= `RWIC_MODE_NORMAL;
      end
    end
  end

  // register read port
  always @(posedge clk_in)
  begin
    if (rst_in)
      rdata_out <= 8'h00;
    else if (rd_in && addr_in == `RWIC_WDOG_ADDR)
      rdata_out <= wdog_value;
    else
      rdata_out <= 8'h00;
  end

  rwic_wdog u_wdog
  (
    .clk_in(clk_in),
    .rst_in(rst_in | in_reset_reg),
    .tick_in(wd_tick_reg),
    .load_in(wdog_wr),
    .load_data_in(wdata_in),
    .value_out(wdog_value),
    .expire_out(wd_expire)
  );
endmodule

// >>> logic/rwic_defs.vh
// constants for the reset, watchdog and interrupt vectoring block
`ifndef RWIC_DEFS_VH
`define RWIC_DEFS_VH
`define RWIC_WDOG_ADDR 8'hD8
`define RWIC_IOR_ADDR 8'hC8
`define RWIC_WDOG_RESET 8'hFE
`define RWIC_SR_BIT 1
`define RWIC_GEN_BIT 4
`define RWIC_STAB_CYCLES 12'h800
`define RWIC_WD_DIV 4'hC
`define RWIC_MC_DIV 4'hD
`define RWIC_PRESCALE 8'hFF
`define RWIC_VEC_RESET 12'hFFE
`define RWIC_VEC_NMI 12'hFFC
`define RWIC_VEC_1 12'hFF6
`define RWIC_VEC_2 12'hFF4
`define RWIC_VEC_3 12'hFF2
`define RWIC_VEC_4 12'hFF0
`define RWIC_MODE_NORMAL 2'h0
`define RWIC_MODE_IRQ 2'h1
`define RWIC_MODE_NMI 2'h2
`endif

// >>> logic/rwic_wdog.v
// watchdog prescaler and bit-reversed six-bit timeout field
`include "rwic_defs.vh"
module rwic_wdog
(
  input wire clk_in,
  input wire rst_in,
  input wire tick_in,
  input wire load_in,
  input wire [7:0] load_data_in,
  output reg [7:0] value_out,
  output reg expire_out
);
  reg [7:0] pre_reg;
  wire [5:0] count_now;
  wire [5:0] count_dec;
  wire [7:0] pre_dec;
  genvar i;
  // field bit 7 is the counter lsb, bit 2 the msb
  generate
    for (i = 0; i < 6; i = i + 1)
    begin : g_rev
      assign count_now[i] = value_out[7 - i];
      always @(posedge clk_in)
      begin
        if (rst_in)
          value_out[7 - i] <= 1'b1;
        else if (load_in)
          value_out[7 - i] <= load_data_in[7 - i];
        else if (tick_in && pre_reg == 8'h00)
          value_out[7 - i] <= count_dec[i];
      end
    end
  endgenerate
  assign count_dec = count_now - 6'h01;
  assign pre_dec = pre_reg - 8'h01;
  // low bits: soft reset and the hardware-cleared activation bit
  always @(posedge clk_in)
  begin
    if (rst_in)
      value_out[1:0] <= 2'b10;
    else if (load_in)
      value_out[1:0] <= {load_data_in[1], 1'b0};
  end
  // 256 watchdog ticks per field step, expire at underflow
  always @(posedge clk_in)
  begin
    if (rst_in)
    begin
      pre_reg <= `RWIC_PRESCALE;
      expire_out <= 1'b0;
    end
    else
    begin
      expire_out <= 1'b0;
      if (load_in)
        pre_reg <= `RWIC_PRESCALE;
      else if (tick_in)
      begin
        pre_reg <= pre_dec;
        if (pre_reg == 8'h00 && count_now == 6'h00)
          expire_out <= 1'b1;
      end
    end
  end
endmodule

// >>> tb/rwic_core_model.sv
// cpu core stand-in giving instruction last-cycle strobes
module rwic_core_model (
  input wire clk_in,
  input wire run_in,
  input wire slow_in,
  output logic last_cycle_out
);
  timeunit 1ns;
  timeprecision 1ps;
  int cnt = 0;
  initial last_cycle_out = 1'b0;
  // strobe every 2 or 5 cycles, changed just after the falling edge
  always @(negedge clk_in)
  begin
    cnt = (cnt >= (slow_in ? 4 : 1)) ? 0 : cnt + 1;
    last_cycle_out = run_in && cnt == 0;
  end
endmodule

// >>> tb/rwic_top_asserts.sv
// assertion checker for the reset, watchdog and interrupt block
`include "rwic_defs.vh"
module rwic_top_asserts (
  input wire clk_in,
  input wire rst_in,
  input wire [7:0] addr_in,
  input wire [7:0] wdata_in,
  input wire wr_in,
  input wire rd_in,
  input wire last_cycle_in,
  input wire stop_in,
  input wire [7:0] rdata_out,
  input wire core_reset_out,
  input wire ports_pullup_out,
  input wire stack_clear_out,
  input wire pc_load_out,
  input wire [11:0] pc_vector_out,
  input wire [1:0] flag_mode_out,
  input wire wait_out,
  input wire machine_cycle_out
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (rst_in);
  // an interrupt vector load outside reset
  wire taken = pc_load_out && !core_reset_out;
  sequence s_soft_write;
    wr_in && addr_in == `RWIC_WDOG_ADDR && !wdata_in[`RWIC_SR_BIT] && !core_reset_out;
  endsequence
  sequence s_nmi_taken;
    taken && pc_vector_out == `RWIC_VEC_NMI;
  endsequence
  property p_soft;
    s_soft_write |-> ##[1:3] core_reset_out;
  endproperty
  a_soft: assert property (p_soft) else $error("soft reset missed");
  property p_rst_state;
    core_reset_out |-> ports_pullup_out && stack_clear_out && pc_vector_out == `RWIC_VEC_RESET
      && flag_mode_out == `RWIC_MODE_NMI;
  endproperty
  a_rst_state: assert property (p_rst_state) else $error("bad reset state");
  property p_vec;
    taken |-> pc_vector_out inside {`RWIC_VEC_NMI, `RWIC_VEC_1, `RWIC_VEC_2, `RWIC_VEC_3, `RWIC_VEC_4};
  endproperty
  a_vec: assert property (p_vec) else $error("bad vector");
  property p_sample;
    taken |-> $past(last_cycle_in);
  endproperty
  a_sample: assert property (p_sample) else $error("load off last cycle");
  property p_one;
    taken |=> !pc_load_out;
  endproperty
  a_one: assert property (p_one) else $error("load too long");
  property p_nest;
    taken && pc_vector_out != `RWIC_VEC_NMI |-> $past(flag_mode_out) == `RWIC_MODE_NORMAL;
  endproperty
  a_nest: assert property (p_nest) else $error("maskable nested");
  property p_nmi;
    s_nmi_taken |-> ##[0:1] flag_mode_out == `RWIC_MODE_NMI;
  endproperty
  a_nmi: assert property (p_nmi) else $error("nmi mode missing");
  property p_wait;
    stop_in |=> wait_out;
  endproperty
  a_wait: assert property (p_wait) else $error("stop not wait");
  property p_rd;
    rd_in && addr_in != `RWIC_WDOG_ADDR |=> rdata_out == 8'h00;
  endproperty
  a_rd: assert property (p_rd) else $error("stray read data");
  property p_mc;
    machine_cycle_out && !core_reset_out |-> ##13 (machine_cycle_out || core_reset_out);
  endproperty
  a_mc: assert property (p_mc) else $error("machine cycle off");
endmodule
bind rwic_top rwic_top_asserts u_chk (.*);

// >>> tb/rwic_top_tb.sv
// self-checking bench for the reset, watchdog and interrupt block
`include "rwic_defs.vh"
module rwic_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_in = 1'b0, rst_in = 1'b1, ext_reset_n_in = 1'b1, wr_in = 1'b0, rd_in = 1'b0;
  logic return_from_interrupt_instr_in = 1'b0, stop_in = 1'b0, nmi_req_in = 1'b1, run = 1'b0, slow = 1'b0, last_cycle_in;
  logic [7:0] addr_in = 8'h00, wdata_in = 8'h00, rdata_out;
  logic [9:0] req_n = 10'h3FF;
  logic core_reset_out, ports_pullup_out, stack_clear_out, pc_load_out, wait_out, machine_cycle_out;
  logic [11:0] pc_vector_out;
  logic [1:0] flag_mode_out;
  int fails = 0, checks = 0, n, i;
  // rows: vector expected for each source, in req_n bit order
  logic [11:0] vec_of [10] = '{`RWIC_VEC_1, `RWIC_VEC_1, `RWIC_VEC_1, `RWIC_VEC_2, `RWIC_VEC_2,
    `RWIC_VEC_2, `RWIC_VEC_3, `RWIC_VEC_3, `RWIC_VEC_4, `RWIC_VEC_4};
  always #4 clk_in = ~clk_in;
  rwic_core_model u_core (.clk_in, .run_in(run), .slow_in(slow), .last_cycle_out(last_cycle_in));
  rwic_top dut (.*, .timer3_req_in(req_n[0]), .porta_req_in(req_n[1]), .portb_req_in(req_n[2]),
    .timer2_req_in(req_n[3]), .vsync_req_in(req_n[4]), .twowire_req_in(req_n[5]),
    .timer1_req_in(req_n[6]), .ddc_req_in(req_n[7]), .adc_req_in(req_n[8]), .power_event_input(req_n[9]));
  task automatic check(input logic [15:0] got, exp);
    checks++;
    if (got !== exp)
    begin
      fails++;
      $display("CHECK FAILED at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic final_report;
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  // one register cycle, strobe held across one rising edge
  task automatic access(input logic w, input logic [7:0] a, d);
    @(negedge clk_in);
    {wr_in, rd_in, addr_in, wdata_in} = {w, !w, a, d};
    @(negedge clk_in);
    {wr_in, rd_in} = 2'b00;
  endtask
  task automatic read_check(input logic [7:0] a, exp);
    // read data stands for the one cycle after the strobe edge; access returns inside it
    access(1'b0, a, 8'h00);
    check(rdata_out, exp);
  endtask
  // clocks until internal reset reaches a level, bounded
  task automatic wait_level(input logic lvl, input int lim);
    n = 0;
    while (core_reset_out !== lvl && n < lim)
    begin
      @(negedge clk_in);
      n++;
    end
  endtask
  task automatic take(input logic [11:0] exp);
    int k = 0;
    @(negedge clk_in);
    while (!(pc_load_out === 1'b1 && core_reset_out === 1'b0) && k < 40)
    begin
      @(negedge clk_in);
      k++;
    end
    check({pc_load_out, pc_vector_out}, {1'b1, exp});
  endtask
  // drop requests and return from the routine
  task automatic leave;
    req_n = 10'h3FF;
    nmi_req_in = 1'b1;
    @(negedge clk_in) return_from_interrupt_instr_in = 1'b1;
    @(negedge clk_in) return_from_interrupt_instr_in = 1'b0;
  endtask
  initial
  begin
    repeat (3) @(negedge clk_in);
    rst_in = 1'b0;
    ext_reset_n_in = 1'b0;
    repeat (4) @(negedge clk_in);
    check({ports_pullup_out, stack_clear_out, pc_vector_out}, {2'b11, `RWIC_VEC_RESET});
    ext_reset_n_in = 1'b1;
    wait_level(1'b0, 2200);
    check(n >= 2048 && n <= 2064, 1'b1);
    read_check(`RWIC_WDOG_ADDR, `RWIC_WDOG_RESET);
    read_check(8'h10, 8'h00);
    access(1'b1, `RWIC_IOR_ADDR, 8'h10);
    run = 1'b1;
    req_n[6] = 1'b0;
    repeat (12) @(negedge clk_in);
    check(flag_mode_out, `RWIC_MODE_NMI);
    leave;
    take(`RWIC_VEC_3);
    leave;
    for (i = 0; i < 10; i++)
    begin
      slow = i[0];
      req_n[i] = 1'b0;
      take(vec_of[i]);
      leave;
    end
    req_n[8] = 1'b0;
    req_n[0] = 1'b0;
    take(`RWIC_VEC_1);
    leave;
    take(`RWIC_VEC_4);
    leave;
    req_n[3] = 1'b0;
    take(`RWIC_VEC_2);
    nmi_req_in = 1'b0;
    take(`RWIC_VEC_NMI);
    leave;
    leave;
    access(1'b1, `RWIC_IOR_ADDR, 8'h00);
    req_n[0] = 1'b0;
    n = 0;
    repeat (30) @(negedge clk_in) n += pc_load_out;
    check(n, 0);
    access(1'b1, `RWIC_IOR_ADDR, 8'h10);
    take(`RWIC_VEC_1);
    leave;
    @(negedge clk_in) stop_in = 1'b1;
    @(negedge clk_in) check(wait_out, 1'b1);
    stop_in = 1'b0;
    access(1'b1, `RWIC_WDOG_ADDR, 8'hFC);
    wait_level(1'b1, 5);
    check(n < 5, 1'b1);
    wait_level(1'b0, 2200);
    check(n >= 2046 && n <= 2064, 1'b1);
    access(1'b1, `RWIC_WDOG_ADDR, 8'h02);
    wait_level(1'b1, 3300);
    check(n < 3090, 1'b1);
    wait_level(1'b0, 2200);
    check(n >= 2046 && n <= 2064, 1'b1);
    final_report;
  end
  // watchdog: the tests need about 80 us
  initial
  begin
    #150us;
    fails++;
    final_report;
  end
endmodule
